// ### core/acc_core.sv
// agp command control: register, operation gating and calibration
//
// Summary of operation
// - calibration code picks 4/16/64/256 ms or none
// - device repeats buffer calibration at chosen period
// - 3.0 mode forces sideband addressing on
// - otherwise sideband follows its enable bit
// - port disabled ignores new operations, sync too
// - accepted operations finish after port disable
// - started 1x sideband command still issues
// - enabled port takes pipe, sideband if enabled
// - above four gig bit reads zero always
// - fast write off or 1x uses plain writes
// - fast write on above 1x uses rate bits
`timescale 1ns/1ps
module acc_core
  import acc_pkg::*;
#(
  parameter int CAL_BASE_CYCLES = ACC_CAL_BASE_CYCLES, // cycles per 4 ms
  parameter int OUT_W = 8 // outstanding counter width
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic agp3ModePin,
  input wire acc_req_t agpReq,
  output acc_grant_t agpGrant,
  output logic busy,
  output logic sidebandActive,
  output logic fastWriteActive,
  output logic [2:0] writeRate,
  output logic calibStart
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  localparam int CNT_W = $clog2(CAL_BASE_CYCLES + 1);
  generate
    if (CAL_BASE_CYCLES < 1 || OUT_W < 1 || OUT_W > 24)
    begin : gBad
      $error("acc_core: unusable parameter values");
    end
  endgenerate

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // 1x only exists outside 3.0 mode
  function automatic logic isOneX(input logic [2:0] rate, input logic mode3);
    isOneX = !mode3 && (rate == ACC_RATE_1X);
  endfunction : isOneX

  // base periods per calibration, zero when none is due
  function automatic logic [ACC_MULT_W-1:0] calMult(input logic [2:0] code);
    case (code)
      ACC_CAL_4MS: calMult = 7'h01;
      ACC_CAL_16MS: calMult = 7'h04;
      ACC_CAL_64MS: calMult = 7'h10;
      ACC_CAL_256MS: calMult = 7'h40;
      default: calMult = 7'h00;
    endcase
  endfunction : calMult

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic modeMeta; // first synchroniser stage
  logic modeSync; // 3.0 mode, synchronised
  logic [2:0] calPeriod; // calibration period code
  logic sbaEnable; // software sideband enable
  logic portEnable; // agp port enable
  logic fastWrite; // fast write enable
  logic [2:0] dataRate; // data rate code
  acc_sba_state_t sbaState; // sideband command progress
  logic [OUT_W-1:0] outCount; // accepted but unfinished
  logic [CNT_W-1:0] unitCnt; // cycles within a base period
  logic [ACC_MULT_W-1:0] multCnt; // base periods elapsed

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire accessFirst = psel && penable && !pready; // answer next edge
  wire accessDone = psel && penable && pready; // master samples now
  wire hitCtrl = (paddr == ACC_CTRL_OFFSET);
  wire hitStat = (paddr == ACC_STAT_OFFSET);
  wire ctrlWrite = accessDone && pwrite && hitCtrl;
  wire writeLow = ctrlWrite && pstrb[0]; // rate and fast write
  wire writeHigh = ctrlWrite && pstrb[1]; // enables and period

  // ------------------------------------------------------------
  // effective modes
  // ------------------------------------------------------------
  wire sbaEff = modeSync || sbaEnable;
  wire oneX = isOneX(dataRate, modeSync);
  wire fwEff = fastWrite && !oneX;

  // ------------------------------------------------------------
  // operation acceptance
  // ------------------------------------------------------------
  wire takePipe = portEnable && agpReq.pipeValid;
  wire takeSync = portEnable && agpReq.syncReq;
  wire sbaStart = portEnable && sbaEff && agpReq.sbaBeat;
  // a command once started completes whatever the enable does
  wire sbaMidEnd = (sbaState == ACC_SBA_MID) && agpReq.sbaBeat
                   && agpReq.sbaLast;
  wire sbaIdleEnd = (sbaState == ACC_SBA_IDLE) && sbaStart
                    && agpReq.sbaLast;
  wire issueSba = sbaMidEnd || sbaIdleEnd;

  acc_sba_state_t next_sbaState;
  always_comb
  begin
    next_sbaState = sbaState;
    case (sbaState)
      ACC_SBA_IDLE:
      begin
        // first beat of a multi beat command
        if (sbaStart && !agpReq.sbaLast)
        begin
          next_sbaState = ACC_SBA_MID;
        end
      end
      ACC_SBA_MID:
      begin
        // no enable check here on purpose
        if (sbaMidEnd)
        begin
          next_sbaState = ACC_SBA_IDLE;
        end
      end
      default:
      begin
        next_sbaState = ACC_SBA_IDLE;
      end
    endcase
  end

  // outstanding work drains whatever the enable says
  wire incOut = takePipe || issueSba;
  wire decOut = agpReq.opDone && (outCount != '0);
  wire outFull = &outCount;
  logic [OUT_W-1:0] next_outCount;
  always_comb
  begin
    next_outCount = outCount;
    if (incOut && !decOut && !outFull)
    begin
      next_outCount = outCount + 1'b1;
    end
    else if (decOut && !incOut)
    begin
      next_outCount = outCount - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // calibration timer
  // ------------------------------------------------------------
  wire [ACC_MULT_W-1:0] calTarget = calMult(calPeriod);
  wire calActive = (calTarget != '0);
  wire unitWrap = (unitCnt == CNT_W'(CAL_BASE_CYCLES - 1));
  wire calDue = calActive && unitWrap
                && (multCnt + 1'b1 == calTarget);
  wire calRestart = writeHigh || !calActive;

  logic [CNT_W-1:0] next_unitCnt;
  logic [ACC_MULT_W-1:0] next_multCnt;
  always_comb
  begin
    next_unitCnt = unitCnt + 1'b1;
    next_multCnt = multCnt;
    if (calRestart)
    begin
      // new period or none: start counting afresh
      next_unitCnt = '0;
      next_multCnt = '0;
    end
    else if (calDue)
    begin
      next_unitCnt = '0;
      next_multCnt = '0;
    end
    else if (unitWrap)
    begin
      next_unitCnt = '0;
      next_multCnt = multCnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] ctrlView;
  logic [31:0] statView;
  always_comb
  begin
    ctrlView = '0;
    ctrlView[ACC_RATE_LSB +: 3] = dataRate;
    ctrlView[ACC_FAST_WRITE_ENABLE_BIT] = fastWrite;
    ctrlView[ACC_GT4_BIT] = 1'b0;
    ctrlView[ACC_PORT_BIT] = portEnable;
    ctrlView[ACC_SIDEBAND_ADDRESSING_ENABLE_BIT] = sbaEnable;
    ctrlView[ACC_CAL_LSB +: 3] = calPeriod;
  end
  always_comb
  begin
    statView = '0;
    statView[ACC_ST_SBA_BIT] = sbaEff;
    statView[ACC_ST_MODE3_BIT] = modeSync;
    statView[ACC_ST_FW_BIT] = fwEff;
    statView[ACC_ST_SBAMID_BIT] = (sbaState == ACC_SBA_MID);
    statView[ACC_ST_OUT_LSB +: OUT_W] = outCount;
  end
  wire [31:0] readMux = hitCtrl ? ctrlView : (hitStat ? statView : 32'h0);

  // ------------------------------------------------------------
  // mode pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    modeMeta <= agp3ModePin;
    modeSync <= modeMeta;
  end

  // ------------------------------------------------------------
  // apb answer, one wait cycle
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= accessFirst;
      pslverr <= accessFirst && !hitCtrl && !hitStat;
      prdata <= accessFirst && !pwrite ? readMux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // control register, low byte
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dataRate <= ACC_RATE_RESET;
      fastWrite <= ACC_BIT_RESET;
    end
    else if (writeLow)
    begin
      dataRate <= pwdata[ACC_RATE_LSB +: 3];
      fastWrite <= pwdata[ACC_FAST_WRITE_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------
  // control register, high byte
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      calPeriod <= ACC_CAL_RESET;
      sbaEnable <= ACC_BIT_RESET;
      portEnable <= ACC_BIT_RESET;
    end
    else if (writeHigh)
    begin
      calPeriod <= pwdata[ACC_CAL_LSB +: 3];
      sbaEnable <= pwdata[ACC_SIDEBAND_ADDRESSING_ENABLE_BIT];
      portEnable <= pwdata[ACC_PORT_BIT];
    end
  end

  // ------------------------------------------------------------
  // operation tracking
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sbaState <= ACC_SBA_IDLE;
      outCount <= '0;
    end
    else
    begin
      sbaState <= next_sbaState;
      outCount <= next_outCount;
    end
  end

  // ------------------------------------------------------------
  // calibration counters
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      unitCnt <= '0;
      multCnt <= '0;
    end
    else
    begin
      unitCnt <= next_unitCnt;
      multCnt <= next_multCnt;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      agpGrant <= '0;
      busy <= 1'b0;
      sidebandActive <= 1'b0;
      fastWriteActive <= 1'b0;
      writeRate <= ACC_RATE_RESET;
      calibStart <= 1'b0;
    end
    else
    begin
      agpGrant.pipeAccept <= takePipe;
      agpGrant.sbaIssue <= issueSba;
      agpGrant.syncAccept <= takeSync;
      busy <= (next_outCount != '0);
      sidebandActive <= sbaEff;
      fastWriteActive <= fwEff;
      writeRate <= dataRate;
      calibStart <= calDue;
    end
  end
endmodule : acc_core

// ### core/acc_pkg.sv
// constants and types shared by the agp command control block
package acc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ACC_ADDR_W = 8;
  localparam logic [7:0] ACC_CTRL_OFFSET = 8'h00; // operation control
  localparam logic [7:0] ACC_STAT_OFFSET = 8'h04; // live status
  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int ACC_RATE_LSB = 0; // data rate, 3 bits
  localparam int ACC_FAST_WRITE_ENABLE_BIT = 4; // fast write enable
  localparam int ACC_GT4_BIT = 5; // above four gig, read only zero
  localparam int ACC_PORT_BIT = 8; // agp port enable
  localparam int ACC_SIDEBAND_ADDRESSING_ENABLE_BIT = 9; // sideband addressing enable
  localparam int ACC_CAL_LSB = 10; // calibration period, 3 bits
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] ACC_CAL_RESET = 3'h2; // 64 ms
  localparam logic [2:0] ACC_RATE_RESET = 3'h0;
  localparam logic ACC_BIT_RESET = 1'h0; // single enable bits
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [2:0] ACC_CAL_4MS = 3'h0;
  localparam logic [2:0] ACC_CAL_16MS = 3'h1;
  localparam logic [2:0] ACC_CAL_64MS = 3'h2;
  localparam logic [2:0] ACC_CAL_256MS = 3'h3;
  localparam logic [2:0] ACC_CAL_NONE = 3'h7;
  localparam logic [2:0] ACC_RATE_1X = 3'h1; // 1x outside 3.0 mode
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int ACC_CLOCK_KHZ = 25000;
  localparam int ACC_CAL_BASE_MS = 4; // shortest period
  localparam int ACC_CAL_BASE_CYCLES = ACC_CAL_BASE_MS * ACC_CLOCK_KHZ;
  localparam int ACC_MULT_W = 7; // base periods per calibration
  // ------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------
  localparam int ACC_ST_SBA_BIT = 0; // sideband in effect
  localparam int ACC_ST_MODE3_BIT = 1; // 3.0 mode seen
  localparam int ACC_ST_FW_BIT = 2; // fast write in effect
  localparam int ACC_ST_SBAMID_BIT = 3; // sideband command mid way
  localparam int ACC_ST_OUT_LSB = 8; // outstanding operations
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic pipeValid; // pipe request this cycle
    logic sbaBeat; // sideband beat this cycle
    logic sbaLast; // beat ends a sideband command
    logic syncReq; // sync cycle request
    logic opDone; // one accepted operation finished
  } acc_req_t;
  typedef struct packed {
    logic pipeAccept; // pipe request taken
    logic sbaIssue; // sideband command issued
    logic syncAccept; // sync cycle taken
  } acc_grant_t;
  typedef enum logic {ACC_SBA_IDLE, ACC_SBA_MID} acc_sba_state_t;
endpackage : acc_pkg

// ### verification/acc_core_assertions.sv
// concurrent checks on the agp command control core ports
`timescale 1ns/1ps
module acc_core_assertions
  import acc_pkg::*;
#(
  parameter int CAL_BASE_CYCLES = 10,
  parameter int OUT_W = 8
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic agp3ModePin,
  input wire acc_req_t agpReq,
  input wire acc_grant_t agpGrant,
  input wire logic busy,
  input wire logic sidebandActive,
  input wire logic fastWriteActive,
  input wire logic [2:0] writeRate,
  input wire logic calibStart
);
  // ----
  // shadow of the control register
  // ----
  logic portEn, sideband_addressing_enable, fast_write_enable, pinQ;
  logic [2:0] rate, calCode, age, pinAge;
  wire wr = psel && penable && pready && pwrite && paddr == ACC_CTRL_OFFSET;
  // shadow follows each committed control write
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {portEn, sideband_addressing_enable, fast_write_enable, rate} <= '0;
      calCode <= ACC_CAL_RESET;
      age <= '0;
    end
    else
    begin
      if (wr && pstrb[0]) {fast_write_enable, rate} <= {pwdata[4], pwdata[2:0]};
      if (wr && pstrb[1]) {calCode, sideband_addressing_enable, portEn} <= pwdata[12:8];
      age <= age + 3'(age != 3'h7);
    end
  end
  // cycles for which the mode pin has not moved
  always_ff @(posedge clock)
  begin
    pinQ <= agp3ModePin;
    // cleared in reset so the age never stays unknown
    if (rst || agp3ModePin != pinQ)
      pinAge <= 3'h0;
    else
      pinAge <= pinAge + 3'(pinAge != 3'h7);
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_ready_pulse: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  chk_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04}))
    else $error("error flag wrong for address");
  chk_resv_zero: assert property (pready && !pwrite && paddr == 8'h00 |->
    (prdata & 32'hFFFFE0E8) == 32'h0)
    else $error("fixed zero control bits read nonzero");
  chk_pipe_gate: assert property (agpReq.pipeValid |=>
    agpGrant.pipeAccept == $past(portEn))
    else $error("pipe grant disagrees with port enable");
  chk_sync_gate: assert property (agpReq.syncReq |=> agpGrant.syncAccept == $past(portEn))
    else $error("sync grant disagrees with port enable");
  chk_sba_end: assert property (agpGrant.sbaIssue |->
    $past(agpReq.sbaBeat && agpReq.sbaLast))
    else $error("sideband issued without a final beat");
  chk_side_mode: assert property (age > 3 && pinAge > 3 &&
    $stable(agp3ModePin) && $stable(sideband_addressing_enable)
    |-> sidebandActive == (sideband_addressing_enable | agp3ModePin))
    else $error("sideband state wrong");
  chk_fast_write: assert property (age > 3 && pinAge > 3 &&
    $stable(fast_write_enable) && $stable(rate)
    |-> fastWriteActive == (fast_write_enable && !(rate == 3'h1 && !agp3ModePin)))
    else $error("fast write state wrong");
  chk_rate_copy: assert property (age > 1 && $stable(rate) |-> writeRate == rate)
    else $error("write rate differs from rate bits");
  chk_cal_none: assert property (calibStart |-> $past(calCode) < 3'h4)
    else $error("calibration pulse with no period");
  chk_busy_hold: assert property (busy && !agpReq.opDone |=> busy)
    else $error("busy dropped with work outstanding");
  cover property (agpGrant.sbaIssue && !portEn);
  cover property (calibStart);
  cover property (pready && pslverr);
endmodule : acc_core_assertions

bind acc_core acc_core_assertions #(
  .CAL_BASE_CYCLES(CAL_BASE_CYCLES),
  .OUT_W(OUT_W)
) acc_core_assertions_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .agp3ModePin(agp3ModePin), .agpReq(agpReq), .agpGrant(agpGrant),
  .busy(busy), .sidebandActive(sidebandActive), .fastWriteActive(fastWriteActive),
  .writeRate(writeRate), .calibStart(calibStart)
);

// ### verification/acc_agp_master.sv
// agp master model: turns bench op codes into one-cycle request pulses
`timescale 1ns/1ps
module acc_agp_master
  import acc_pkg::*;
(
  input wire logic clock,
  input wire logic [2:0] opCode,
  output acc_req_t agpReq
);
  initial agpReq = '0;
  // 1 pipe, 2 sync, 3 sideband beat, 4 final beat, 5 operation done
  // one assignment per edge; field order pipe, beat, last, sync, done
  always @(posedge clock)
  begin
    case (opCode)
      3'h1: agpReq <= 5'h10; // pipe request
      3'h2: agpReq <= 5'h02; // sync request
      3'h3: agpReq <= 5'h08; // sideband beat, more to follow
      3'h4: agpReq <= 5'h0C; // final sideband beat
      3'h5: agpReq <= 5'h01; // operation done
      default: agpReq <= 5'h00;
    endcase
  end
endmodule : acc_agp_master

// ### verification/tb_agp_command_control.sv
// self-checking bench for the agp command control core
`timescale 1ns/1ps
module tb_agp_command_control
  import acc_pkg::*;
;
  localparam int CAL_BASE = 10; // short calibration base
  logic clock, rst, psel, penable, pwrite, agp3ModePin, pready, pslverr, busy;
  logic sidebandActive, fastWriteActive, calibStart;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v, m, cur;
  logic [3:0] pstrb, strb;
  logic [2:0] writeRate, opCode;
  acc_req_t agpReq;
  acc_grant_t agpGrant;
  logic [32:0] q[$]; // expected reads, error flag on top
  logic [2:0] gq[$]; // expected grants
  int fails, samplesChecked, seed, k;
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  acc_core #(.CAL_BASE_CYCLES(CAL_BASE), .OUT_W(8)) acc_core_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .agp3ModePin(agp3ModePin), .agpReq(agpReq), .agpGrant(agpGrant),
    .busy(busy), .sidebandActive(sidebandActive), .fastWriteActive(fastWriteActive),
    .writeRate(writeRate), .calibStart(calibStart));
  acc_agp_master acc_agp_master_i (.clock(clock), .opCode(opCode), .agpReq(agpReq));
  task chk(input logic [32:0] e, input logic [32:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task results;
    if (fails == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    if (!w) q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wrCtl(input logic [31:0] d);
    apb(1'b1, ACC_CTRL_OFFSET, d, '0);
  endtask : wrCtl
  task rdStat(input logic [32:0] e);
    apb(1'b0, ACC_STAT_OFFSET, '0, e);
  endtask : rdStat
  // one master request, with the grant it should earn
  task op(input logic [2:0] c, input logic [2:0] g);
    @(posedge clock);
    opCode <= c;
    if (g !== 3'h0) gq.push_back(g);
    @(posedge clock);
    opCode <= 3'h0;
  endtask : op
  // count calibration pulses in a fixed window after a period write
  task cal(input int c);
    int n;
    n = 0;
    wrCtl(32'(c) << 10);
    repeat (695)
    begin
      @(posedge clock);
      n += int'(calibStart === 1'b1);
    end
    chk(33'(c < 4 ? 694 / (CAL_BASE << (2 * c)) : 0), 33'(n));
  endtask : cal
  // compare each read answer and each grant with the oldest expectation
  always @(posedge clock)
  begin
    if (pready === 1'b1 && pwrite === 1'b0)
      chk(q.size() ? q.pop_front() : 'x, {pslverr, pslverr ? 32'h0 : prdata});
    if (agpGrant !== 3'h0)
      chk(gq.size() ? gq.pop_front() : 'x, 33'(agpGrant));
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
  initial
  begin
    {rst, psel, penable, pwrite, agp3ModePin} = 5'h10;
    {paddr, pwdata, opCode} = '0;
    {strb, pstrb} = 8'hFF;
    {fails, samplesChecked, seed} = {32'h0, 32'h0, 32'h1D};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, ACC_CTRL_OFFSET, '0, 33'h800);
    rdStat(33'h0);
    apb(1'b0, 8'h08, '0, 33'h100000000);
    cur = 32'h800;
    repeat (6)
    begin
      v = $random(seed);
      strb = 4'($random(seed));
      m = {16'h0, {8{strb[1]}}, {8{strb[0]}}};
      cur = ((v & m) | (cur & ~m)) & 32'h1F17;
      wrCtl(v);
      strb = 4'hF;
      apb(1'b0, ACC_CTRL_OFFSET, '0, {1'b0, cur});
    end
    // status is read only: a write there leaves control untouched
    apb(1'b1, ACC_STAT_OFFSET, 32'h1F17, '0);
    apb(1'b0, ACC_CTRL_OFFSET, '0, {1'b0, cur});
    wrCtl(32'h800);
    op(3'h1, 3'h0);
    op(3'h2, 3'h0);
    op(3'h4, 3'h0);
    wrCtl(32'h901);
    op(3'h1, 3'h4);
    op(3'h2, 3'h1);
    op(3'h4, 3'h0);
    rdStat(33'h100);
    wrCtl(32'hB01);
    op(3'h4, 3'h2);
    op(3'h3, 3'h0);
    wrCtl(32'h801);
    rdStat(33'h208);
    op(3'h4, 3'h2);
    op(3'h1, 3'h0);
    rdStat(33'h300);
    repeat (3) op(3'h5, 3'h0);
    agp3ModePin <= 1'b1;
    wrCtl(32'h900);
    op(3'h4, 3'h2);
    rdStat(33'h103);
    op(3'h5, 3'h0);
    agp3ModePin <= 1'b0;
    for (k = 0; k < 8; k++)
    begin
      wrCtl(32'h810 | 32'(k));
      rdStat({30'h0, k != 1, 2'h0});
    end
    wrCtl(32'h803);
    rdStat(33'h0);
    for (k = 0; k < 8; k++) cal(k);
    chk(33'h0, 33'(q.size() + gq.size()));
    results();
  end
endmodule : tb_agp_command_control
